// >>> logic/srpc_pkg.sv
// Constants and types shared by the serial register port with optional CRC
// ============================================================================
// Summary of operation
// R1 - Hardware reset clears CRC enable, soft reset keeps
// R2 - CRC enable written by ordinary access anytime
// R3 - CRC enable selects extended frames both directions
// R4 - CRC off: frames are exactly four bytes
// R5 - CRC on: frames are five bytes, last CRC
// R6 - Host appends CRC over four write bytes
// R7 - Write CRC mismatch raises CRC error flag
// R8 - Reads ignore host fifth byte, no check
// R9 - Read CRC covers host byte plus data
// R10 - Host alone checks returned read CRC
// R11 - Command: address, read/write bit, 24 data bits
// R12 - Four-byte frame: address, flag, payload layout
// R13 - CRC eight bits, polynomial 0x31
// R14 - CRC init zero, xorout zero, reflected
// R15 - CRC spans the plain 32-bit frame
// R16 - Supply loss flags while low supplies valid
// R17 - Five-byte frame: address, flag, payload, CRC
// R18 - Ignore clock and idle output unless selected
// R19 - Read/write one reads; MSB first shifting
// R20 - Failed-CRC write leaves register unchanged
package srpc_pkg;

  // ==========================================================================
  // Frame layout
  localparam int ADDR_W            = 7;
  localparam int DATA_W            = 24;
  localparam int CRC_W             = 8;
  localparam int BYTE_BITS         = 8;
  localparam int FRAME_BYTES_PLAIN = 4;
  localparam int FRAME_BYTES_CRC   = 5;
  localparam int WORD_W            = FRAME_BYTES_PLAIN * BYTE_BITS;
  localparam int WORD_ADDR_MSB     = 31;
  localparam int WORD_ADDR_LSB     = 25;
  localparam int WORD_RW_BIT       = 24;
  localparam logic RW_READ         = 1'b1;

  // Bit counter values at the rising edge that samples a given bit
  localparam logic [5:0] CNT_RW_BIT    = 6'(BYTE_BITS - 1);
  localparam logic [5:0] CNT_WORD_LAST = 6'(WORD_W - 1);
  localparam logic [5:0] CNT_CRC_LAST  = 6'(FRAME_BYTES_CRC * BYTE_BITS - 1);
  localparam logic [5:0] CNT_DONE_PLN  = 6'(WORD_W);
  localparam logic [5:0] CNT_DONE_CRC  = 6'(FRAME_BYTES_CRC * BYTE_BITS);

  // ==========================================================================
  // CRC parameters
  localparam logic [7:0] CRC_POLY      = 8'h31;
  // Bit-reversed form of the polynomial for the reflected algorithm
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
  localparam logic [7:0] CRC_INIT      = 8'h00;
  localparam logic [7:0] CRC_XOR_OUT   = 8'h00;

  // ==========================================================================
  // Register map
  localparam logic [6:0] STATUS_ADDR      = 7'h00;
  localparam logic [6:0] CONFIG_ADDR      = 7'h01;
  localparam int         CFG_CRC_EN_BIT   = 0;
  localparam int         CFG_SOFT_RST_BIT = 1;
  localparam int         STATUS_W         = 3;

  // ==========================================================================
  // Synchronisers
  localparam int SYNC_STAGES = 3;
  localparam int IN_LV       = 0;
  localparam int IN_MAIN_HV  = 1;
  localparam int IN_OUT_HV   = 2;
  localparam int IN_WR_TGL   = 3;
  localparam int IN_ERR_TGL  = 4;
  localparam int SYS_IN_N    = 5;
  localparam int LINK_IN_N   = STATUS_W + 1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } srpc_wr_s;

  typedef struct packed {
    logic crc_err;
    logic out_hv;
    logic main_hv;
  } srpc_status_s;

endpackage : srpc_pkg

// >>> logic/srpc_crc8.sv
// One-byte step of the reflected CRC-8
`timescale 1ns/1ps
module srpc_crc8
  import srpc_pkg::*;
(
  // Running value and next byte
  input  wire logic [CRC_W-1:0] crc_in,
  input  wire logic [7:0]       byte_in,
  // Updated value
  output logic      [CRC_W-1:0] crc_out
);

  // ==========================================================================
  // Reflected shift: low bit of the byte enters first
  always_comb begin
    crc_out = crc_in ^ byte_in;
    // R13 generator polynomial
    // R14 reflected bytes
    for (int i = 0; i < BYTE_BITS; i++) begin
      crc_out = crc_out[0] ? ((crc_out >> 1) ^ CRC_POLY_REFL) : (crc_out >> 1);
    end
  end

endmodule : srpc_crc8

// >>> logic/srpc_spi_port.sv
// Serial register port with optional CRC, supply-loss status and crossings
`timescale 1ns/1ps
module srpc_spi_port
  import srpc_pkg::*;
(
  // System clock domain
  input  wire logic     clock,
  input  wire logic     reset,
  input  wire logic     clock_enable,
  // Serial link
  input  wire logic     sclk,
  input  wire logic     cs_n,
  input  wire logic     sdi,
  output logic          sdo,
  output logic          sdo_oe_n,
  // Supply monitors
  input  wire logic     lv_supply_valid,
  input  wire logic     main_hv_loss,
  input  wire logic     output_hv_loss,
  // Control and status
  output logic          crc_enable,
  output logic          soft_reset_pulse,
  output logic          main_hv_supply_loss_flag,
  output logic          output_hv_supply_loss_flag,
  output logic          crc_error_flag,
  // Forwarded register writes
  output logic          reg_wr_valid,
  output srpc_wr_s      reg_wr
);

  // ==========================================================================
  // Declarations
  logic [5:0]           bit_cnt_reg;
  logic [WORD_W-1:0]    rx_shift_reg;
  logic [WORD_W-1:0]    word_hold_reg;
  logic [DATA_W-1:0]    tx_shift_reg;
  logic [DATA_W-1:0]    rd_word_reg;
  logic [CRC_W-1:0]     crc_reg;
  logic                 rw_reg;
  logic                 sdo_reg;
  logic                 sdo_oe_n_reg;
  srpc_wr_s             ev_reg;
  logic                 wr_tgl_reg;
  logic                 err_tgl_reg;
  logic [DATA_W-1:0]    mem [0:(1<<ADDR_W)-1];
  logic                 crc_enable_reg;
  logic                 soft_reset_reg;
  srpc_status_s         general_interrupt_status_reg;
  logic                 reg_wr_valid_reg;
  srpc_wr_s             reg_wr_reg;
  logic [1:0]           tgl_prev_reg;
  wire  [SYS_IN_N-1:0]  sys_async_in;
  wire  [SYS_IN_N-1:0]  sys_filt;
  wire  [LINK_IN_N-1:0] link_async_in;
  wire  [LINK_IN_N-1:0] link_filt;

  // ==========================================================================
  // Link-side decode
  wire              crc_on      = link_filt[STATUS_W];
  wire [STATUS_W-1:0] link_status = link_filt[STATUS_W-1:0];
  wire [WORD_W-1:0] rx_word     = {rx_shift_reg[WORD_W-2:0], sdi};
  wire [7:0]        rx_byte     = rx_word[7:0];
  wire [ADDR_W-1:0] rd_addr     = rx_shift_reg[ADDR_W-1:0];
  wire              is_rw_bit   = (bit_cnt_reg == CNT_RW_BIT);
  wire              is_word_end = (bit_cnt_reg == CNT_WORD_LAST);
  wire              is_crc_end  = (bit_cnt_reg == CNT_CRC_LAST);
  wire              byte_end    = (bit_cnt_reg[2:0] == 3'h7) && (bit_cnt_reg <= CNT_WORD_LAST);
  // R3 CRC mode selects frame
  wire              load_crc    = is_word_end && rw_reg && crc_on;
  // R19 read when flag is one
  wire              is_write    = (rw_reg != RW_READ);

  // R11 address, flag, payload
  // R12 plain frame layout
  wire [DATA_W-1:0] rd_word =
    (rd_addr == STATUS_ADDR) ? {21'h0, link_status} :
    (rd_addr == CONFIG_ADDR) ? {23'h0, crc_on} :
    mem[rd_addr];

  // R9 read CRC takes the returned bytes
  wire [7:0] tx_byte =
    (bit_cnt_reg[4:3] == 2'h1) ? rd_word_reg[23:16] :
    (bit_cnt_reg[4:3] == 2'h2) ? rd_word_reg[15:8] :
    rd_word_reg[7:0];
  wire       crc_sel_rx = is_rw_bit || is_write;
  wire [7:0] crc_byte   = crc_sel_rx ? rx_byte : tx_byte;
  wire [7:0] crc_now;

  // R15 CRC spans the first four bytes
  srpc_crc8 u_crc (
    .crc_in  (crc_reg),
    .byte_in (crc_byte),
    .crc_out (crc_now)
  );

  wire [DATA_W-1:0] tx_next =
    is_rw_bit ? rd_word :
    load_crc  ? {crc_now ^ CRC_XOR_OUT, 16'h0} :
    {tx_shift_reg[DATA_W-2:0], 1'b0};

  // R4 plain write ends at bit 31
  wire commit_plain = is_word_end && is_write && !crc_on;
  // R5 fifth byte checked last
  // R8 reads skip the check
  wire crc_check    = is_crc_end && is_write && crc_on;
  // R7 compare received and computed CRC
  wire crc_ok       = (rx_byte == (crc_reg ^ CRC_XOR_OUT));
  // R20 only a matching CRC commits
  wire commit       = commit_plain || (crc_check && crc_ok);
  wire crc_fail     = crc_check && !crc_ok;
  // R17 extended frame keeps the word in bits 39 to 8
  wire [WORD_W-1:0] sel_word = commit_plain ? rx_word : word_hold_reg;
  srpc_wr_s         wr_word;
  assign wr_word = {sel_word[WORD_ADDR_MSB:WORD_ADDR_LSB], sel_word[DATA_W-1:0]};
  wire wr_is_gen = (wr_word.addr != STATUS_ADDR) && (wr_word.addr != CONFIG_ADDR);

  // ==========================================================================
  // Link shift logic, cleared whenever the port is deselected
  // R18 deselect resets the link
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg   <= 6'h00;
      rx_shift_reg  <= 32'h0;
      word_hold_reg <= 32'h0;
      tx_shift_reg  <= 24'h0;
      rd_word_reg   <= 24'h0;
      crc_reg       <= CRC_INIT;
      rw_reg        <= 1'b0;
    end else begin
      if (bit_cnt_reg != CNT_DONE_CRC) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      // R19 most significant bit first
      rx_shift_reg <= rx_word;
      tx_shift_reg <= tx_next;
      if (is_rw_bit) begin
        rw_reg      <= sdi;
        rd_word_reg <= rd_word;
      end
      if (is_word_end) begin
        word_hold_reg <= rx_word;
      end
      if (byte_end) begin
        crc_reg <= crc_now;
      end
    end
  end

  // Output stage changes on the falling edge, idle while deselected
  // R18 output inactive unless selected
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdo_reg      <= 1'b0;
      sdo_oe_n_reg <= 1'b1;
    end else begin
      sdo_reg      <= !is_write && (bit_cnt_reg > CNT_RW_BIT) && tx_shift_reg[DATA_W-1];
      sdo_oe_n_reg <= 1'b0;
    end
  end

  // Write events held stable for the system side to pick up
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      ev_reg      <= '0;
      wr_tgl_reg  <= 1'b0;
      err_tgl_reg <= 1'b0;
    end else begin
      if (commit) begin
        ev_reg     <= wr_word;
        wr_tgl_reg <= !wr_tgl_reg;
      end
      // R7 mismatch raises error event
      if (crc_fail) begin
        err_tgl_reg <= !err_tgl_reg;
      end
    end
  end

  // Register storage for addresses other than status and config
  always_ff @(posedge sclk) begin
    if (commit && wr_is_gen) begin
      mem[wr_word.addr] <= wr_word.data;
    end
  end

  // ==========================================================================
  // Crossings: three stages, a change counts once stages two and three agree
  assign sys_async_in  = {err_tgl_reg, wr_tgl_reg, output_hv_loss, main_hv_loss, lv_supply_valid};
  assign link_async_in = {crc_enable_reg, general_interrupt_status_reg};

  for (genvar g = 0; g < SYS_IN_N; g++) begin : g_sys_sync
    logic [SYNC_STAGES-1:0] pipe_reg;
    logic                   filt_reg;
    always_ff @(posedge clock) begin
      if (reset) begin
        pipe_reg <= '0;
        filt_reg <= 1'b0;
      end else if (clock_enable) begin
        pipe_reg <= {pipe_reg[SYNC_STAGES-2:0], sys_async_in[g]};
        if (pipe_reg[SYNC_STAGES-2] == pipe_reg[SYNC_STAGES-1]) begin
          filt_reg <= pipe_reg[SYNC_STAGES-1];
        end
      end
    end
    assign sys_filt[g] = filt_reg;
  end

  for (genvar g = 0; g < LINK_IN_N; g++) begin : g_link_sync
    logic [SYNC_STAGES-1:0] pipe_reg;
    logic                   filt_reg;
    always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
        pipe_reg <= '0;
        filt_reg <= 1'b0;
      end else begin
        pipe_reg <= {pipe_reg[SYNC_STAGES-2:0], link_async_in[g]};
        if (pipe_reg[SYNC_STAGES-2] == pipe_reg[SYNC_STAGES-1]) begin
          filt_reg <= pipe_reg[SYNC_STAGES-1];
        end
      end
    end
    assign link_filt[g] = filt_reg;
  end

  // ==========================================================================
  // System-side control and status
  wire wr_ev   = sys_filt[IN_WR_TGL] ^ tgl_prev_reg[0];
  wire err_ev  = sys_filt[IN_ERR_TGL] ^ tgl_prev_reg[1];
  wire cfg_wr  = wr_ev && (ev_reg.addr == CONFIG_ADDR);
  wire st_wr   = wr_ev && (ev_reg.addr == STATUS_ADDR);
  wire gen_wr  = wr_ev && (ev_reg.addr != CONFIG_ADDR) && (ev_reg.addr != STATUS_ADDR);
  wire soft_ev = cfg_wr && ev_reg.data[CFG_SOFT_RST_BIT];
  wire lv_ok   = sys_filt[IN_LV];

  // R16 loss flags only while low supplies valid
  wire [STATUS_W-1:0] st_set = {err_ev, lv_ok && sys_filt[IN_OUT_HV], lv_ok && sys_filt[IN_MAIN_HV]};
  wire [STATUS_W-1:0] st_clr = (st_wr ? ev_reg.data[STATUS_W-1:0] : 3'h0) | {STATUS_W{soft_ev}};
  // Set wins over a clear in the same cycle
  wire [STATUS_W-1:0] st_next = st_set | (general_interrupt_status_reg & ~st_clr);

  always_ff @(posedge clock) begin
    if (reset) begin
      // R1 hardware reset disables CRC
      crc_enable_reg               <= 1'b0;
      soft_reset_reg               <= 1'b0;
      general_interrupt_status_reg <= '0;
      reg_wr_valid_reg             <= 1'b0;
      reg_wr_reg                   <= '0;
      tgl_prev_reg                 <= 2'h0;
    end else if (clock_enable) begin
      tgl_prev_reg                 <= sys_filt[IN_ERR_TGL:IN_WR_TGL];
      // R2 plain register write sets CRC enable
      // R1 soft reset leaves CRC enable alone
      if (cfg_wr && !soft_ev) begin
        crc_enable_reg <= ev_reg.data[CFG_CRC_EN_BIT];
      end
      soft_reset_reg               <= soft_ev;
      general_interrupt_status_reg <= st_next;
      reg_wr_valid_reg             <= gen_wr;
      if (gen_wr) begin
        reg_wr_reg <= ev_reg;
      end
    end
  end

  assign sdo                        = sdo_reg;
  assign sdo_oe_n                   = sdo_oe_n_reg;
  assign crc_enable                 = crc_enable_reg;
  assign soft_reset_pulse           = soft_reset_reg;
  assign main_hv_supply_loss_flag   = general_interrupt_status_reg.main_hv;
  assign output_hv_supply_loss_flag = general_interrupt_status_reg.out_hv;
  assign crc_error_flag             = general_interrupt_status_reg.crc_err;
  assign reg_wr_valid               = reg_wr_valid_reg;
  assign reg_wr                     = reg_wr_reg;

  // ==========================================================================
  // Assertions
  sequence s_plain_write_done;
    (bit_cnt_reg == CNT_DONE_PLN) && is_write && !crc_on;
  endsequence
  sequence s_crc_write_done;
    (bit_cnt_reg == CNT_DONE_CRC) && is_write && crc_on;
  endsequence

  property p_plain_commit;
    @(negedge sclk) disable iff (cs_n)
      s_plain_write_done |-> (wr_tgl_reg != $past(wr_tgl_reg));
  endproperty
  a_plain_commit: assert property (p_plain_commit) else $error("plain write not committed"); // R4

  property p_crc_fail_flag;
    @(negedge sclk) disable iff (cs_n)
      s_crc_write_done ##0 (rx_shift_reg[7:0] != crc_reg) |-> (err_tgl_reg != $past(err_tgl_reg));
  endproperty
  a_crc_fail_flag: assert property (p_crc_fail_flag) else $error("CRC mismatch not flagged"); // R7

  property p_crc_fail_nowrite;
    @(negedge sclk) disable iff (cs_n)
      s_crc_write_done ##0 (rx_shift_reg[7:0] != crc_reg) |-> (wr_tgl_reg == $past(wr_tgl_reg));
  endproperty
  a_crc_fail_nowrite: assert property (p_crc_fail_nowrite) else $error("failed CRC write committed"); // R20

  property p_crc_pass_write;
    @(negedge sclk) disable iff (cs_n)
      s_crc_write_done ##0 (rx_shift_reg[7:0] == crc_reg) |-> (wr_tgl_reg != $past(wr_tgl_reg));
  endproperty
  a_crc_pass_write: assert property (p_crc_pass_write) else $error("good CRC write lost"); // R5

  property p_read_no_check;
    @(negedge sclk) disable iff (cs_n)
      (bit_cnt_reg == CNT_DONE_CRC) && !is_write |-> (err_tgl_reg == $past(err_tgl_reg));
  endproperty
  a_read_no_check: assert property (p_read_no_check) else $error("read raised CRC error"); // R8

  property p_read_crc;
    @(posedge sclk) disable iff (cs_n)
      load_crc |=> (tx_shift_reg[DATA_W-1:DATA_W-CRC_W] == $past(crc_now));
  endproperty
  a_read_crc: assert property (p_read_crc) else $error("read CRC byte not loaded"); // R9

  property p_soft_keeps_crc;
    @(posedge clock) disable iff (reset)
      soft_ev && clock_enable |=> $stable(crc_enable_reg);
  endproperty
  a_soft_keeps_crc: assert property (p_soft_keeps_crc) else $error("soft reset changed CRC enable"); // R1

  property p_cfg_write;
    @(posedge clock) disable iff (reset)
      cfg_wr && !soft_ev && clock_enable |=> (crc_enable_reg == $past(ev_reg.data[CFG_CRC_EN_BIT]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("CRC enable write ignored"); // R2

  property p_hv_flag;
    @(posedge clock) disable iff (reset)
      lv_ok && sys_filt[IN_MAIN_HV] && clock_enable |=> main_hv_supply_loss_flag;
  endproperty
  a_hv_flag: assert property (p_hv_flag) else $error("main supply loss not flagged"); // R16

endmodule : srpc_spi_port

// >>> dv/srpc_host_model.sv
// Serial host model that frames register accesses into the port
`timescale 1ns/1ps
module srpc_host_model
  import srpc_pkg::*;
(
  // Serial link toward the port
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  // Answer from the port
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  // ==========================================================================
  // Link timing
  localparam realtime HALF = 7.5;

  initial begin
    sclk = 1'b0;
    sdi  = 1'b1;
    // Raised after time zero so the port sees a real deselect edge
    #1 cs_n = 1'b1;
  end

  // ==========================================================================
  // Check byte
  // reflected eight-bit code
  function automatic logic [7:0] crc8(input logic [31:0] word);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 3; i >= 0; i--) begin
      c = c ^ word[i*8 +: 8];
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 8'h8c) : (c >> 1);
      end
    end
    return c;
  endfunction : crc8

  // ==========================================================================
  // Frame transfer
  // whole frame, first bit leading
  task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx   = '0;
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      #HALF sclk = 1'b1;
      rx[i] = sdo;
      #HALF sclk = 1'b0;
    end
    #HALF cs_n = 1'b1;
    // Released line shows the inverse, not the last bit
    sdi = ~sdi;
    #(4 * HALF);
  endtask : frame

endmodule : srpc_host_model

// >>> dv/srpc_spi_port_tb.sv
// Self-checking bench for the serial register port with optional CRC
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module srpc_spi_port_tb
  import srpc_pkg::*;
;
  logic     clock;
  logic     reset;
  logic     clock_enable;
  logic     lv_supply_valid;
  logic     main_hv_loss;
  logic     output_hv_loss;
  wire      sclk;
  wire      cs_n;
  wire      sdi;
  logic     sdo;
  logic     sdo_oe_n;
  logic     crc_enable;
  logic     soft_reset_pulse;
  logic     main_hv_supply_loss_flag;
  logic     output_hv_supply_loss_flag;
  logic     crc_error_flag;
  logic     reg_wr_valid;
  srpc_wr_s reg_wr;
  srpc_wr_s wr_last;
  int       errors;
  int       samples_checked;
  int       wr_seen;
  int       sr_seen;
  logic     crc_on;
  logic [23:0] d;
  logic [7:0]  c;

  srpc_spi_port dut (
    .clock(clock), .reset(reset), .clock_enable(clock_enable),
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .lv_supply_valid(lv_supply_valid), .main_hv_loss(main_hv_loss), .output_hv_loss(output_hv_loss),
    .crc_enable(crc_enable), .soft_reset_pulse(soft_reset_pulse),
    .main_hv_supply_loss_flag(main_hv_supply_loss_flag),
    .output_hv_supply_loss_flag(output_hv_supply_loss_flag),
    .crc_error_flag(crc_error_flag), .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr)
  );

  srpc_host_model host (
    .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n)
  );

  // ==========================================================================
  // Clock, pulse monitor, closing
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    if (reg_wr_valid === 1'b1) begin
      wr_seen++;
      wr_last = reg_wr;
    end
    if (soft_reset_pulse === 1'b1) begin
      sr_seen++;
    end
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  // ==========================================================================
  // Access helpers
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic wr(input logic [6:0] a, input logic [23:0] dv, input logic bad);
    logic [31:0] w;
    logic [39:0] rx;
    w = {a, 1'b0, dv};
    if (crc_on) begin
      host.frame({w, host.crc8(w) ^ {7'h00, bad}}, 40, rx);
    end else begin
      host.frame({8'h00, w}, 32, rx);
    end
    step(40);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [23:0] dv, output logic [7:0] cv);
    logic [39:0] rx;
    if (crc_on) begin
      // Junk in the check byte and payload slots
      host.frame({a, 1'b1, 24'h5a5a5a, 8'ha5}, 40, rx);
      dv = rx[31:8];
      cv = rx[7:0];
    end else begin
      host.frame({8'h00, a, 1'b1, 24'h5a5a5a}, 32, rx);
      dv = rx[23:0];
      cv = 8'h00;
    end
    step(40);
  endtask : rd

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    `CHK(crc_enable, 1'b0)
    `CHK({crc_error_flag, output_hv_supply_loss_flag, main_hv_supply_loss_flag}, 3'h0)
    `CHK({sdo_oe_n, sdo}, 2'h2)
  endtask : t_reset

  task automatic t_plain;
    int n;
    n = wr_seen;
    wr(7'h05, 24'h123456, 1'b0);
    `CHK(wr_last, {7'h05, 24'h123456})
    wr(7'h7f, 24'hfedcba, 1'b0);
    `CHK(wr_seen, n + 2)
    `CHK(wr_last, {7'h7f, 24'hfedcba})
    rd(7'h05, d, c);
    `CHK(d, 24'h123456)
    rd(7'h7f, d, c);
    `CHK(d, 24'hfedcba)
  endtask : t_plain

  task automatic t_crc;
    int n;
    `CHK(host.crc8(32'h06000f00), 8'h11)
    wr(CONFIG_ADDR, 24'h000001, 1'b0);
    crc_on = 1'b1;
    `CHK(crc_enable, 1'b1)
    n = wr_seen;
    wr(7'h06, 24'h000f00, 1'b0);
    `CHK(wr_seen, n + 1)
    `CHK(crc_error_flag, 1'b0)
    wr(7'h06, 24'h111111, 1'b1);
    `CHK(wr_seen, n + 1)
    `CHK(crc_error_flag, 1'b1)
    // Clear the error so a read that raised it would show
    wr(STATUS_ADDR, 24'h000004, 1'b0);
    `CHK(crc_error_flag, 1'b0)
    rd(7'h06, d, c);
    `CHK(d, 24'h000f00)
    `CHK(c, host.crc8({7'h06, 1'b1, 24'h000f00}))
    `CHK(crc_error_flag, 1'b0)
    rd(CONFIG_ADDR, d, c);
    `CHK(d, 24'h000001)
    `CHK(c, host.crc8({CONFIG_ADDR, 1'b1, 24'h000001}))
  endtask : t_crc

  task automatic t_soft;
    int n;
    n = sr_seen;
    wr(7'h06, 24'h222222, 1'b1);
    `CHK(crc_error_flag, 1'b1)
    wr(CONFIG_ADDR, 24'h000002, 1'b0);
    `CHK(sr_seen, n + 1)
    `CHK(crc_enable, 1'b1)
    `CHK(crc_error_flag, 1'b0)
  endtask : t_soft

  task automatic t_supply;
    lv_supply_valid = 1'b0;
    main_hv_loss    = 1'b1;
    step(20);
    `CHK(main_hv_supply_loss_flag, 1'b0)
    lv_supply_valid = 1'b1;
    step(20);
    `CHK({output_hv_supply_loss_flag, main_hv_supply_loss_flag}, 2'h1)
    main_hv_loss   = 1'b0;
    output_hv_loss = 1'b1;
    step(20);
    `CHK(output_hv_supply_loss_flag, 1'b1)
    output_hv_loss = 1'b0;
    step(20);
    rd(STATUS_ADDR, d, c);
    `CHK(d, 24'h000003)
    `CHK(c, host.crc8({STATUS_ADDR, 1'b1, 24'h000003}))
    wr(STATUS_ADDR, 24'h000007, 1'b0);
    `CHK({output_hv_supply_loss_flag, main_hv_supply_loss_flag}, 2'h0)
  endtask : t_supply

  task automatic t_hw_reset;
    reset = 1'b1;
    step(10);
    reset = 1'b0;
    step(8);
    crc_on = 1'b0;
    `CHK(crc_enable, 1'b0)
    wr(7'h40, 24'h0a0b0c, 1'b0);
    rd(7'h40, d, c);
    `CHK(d, 24'h0a0b0c)
  endtask : t_hw_reset

  initial begin
    errors          = 0;
    samples_checked = 0;
    wr_seen         = 0;
    sr_seen         = 0;
    crc_on          = 1'b0;
    reset           = 1'b0;
    clock_enable    = 1'b1;
    lv_supply_valid = 1'b1;
    main_hv_loss    = 1'b0;
    output_hv_loss  = 1'b0;
    // Raised after time zero so the link-side holders see a reset edge
    #1 reset = 1'b1;
    step(10);
    reset = 1'b0;
    step(8);
    t_reset();
    t_plain();
    t_crc();
    t_soft();
    t_supply();
    t_hw_reset();
    end_of_test();
  end

endmodule : srpc_spi_port_tb
